// ---- logic/prs_pkg.sv ----
/*
 * Constants, types and carriers of the pixel readout sequencer.
 * Assumes a 100 MHz readout clock and an APB register port.
 */
package prs_pkg;
   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam logic [11:0] ADDR_MODE = 12'h000;
   localparam logic [11:0] ADDR_STAT = 12'h004;
   localparam logic [4:0] MODE_RST = 5'h14;
   localparam int MODE_TEST_BIT = 0;
   localparam int MODE_SERIAL_BIT = 2;
   localparam int MODE_MARK_BIT = 4;

   // -----------------------------------------------------------------
   // Timing and geometry
   // -----------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int PIX_MHZ = 10;
   localparam logic [3:0] SLOTS = 4'(CLK_MHZ / PIX_MHZ);
   localparam logic [3:0] SLOT_LAST = 4'(SLOTS - 4'h1);
   localparam logic [3:0] SLOT_HALF = 4'(SLOTS / 4'h2);
   localparam logic [3:0] SLOT_FILL0 = 4'h2;
   localparam logic [2:0] START_LAT = 3'h4;
   localparam logic [6:0] ROW_TOP = 7'h7F;
   localparam logic [6:0] POS_PX0 = 7'h02;
   localparam logic [6:0] POS_LAST = 7'h41;
   localparam logic [3:0] PAR_LEFT_PAT = 4'h9;
   localparam logic [7:0] SER_TST_LEFT = 8'h15;
   localparam logic [7:0] SER_TST_HIGH = 8'h69;

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      SRC_IDLE = 3'h0, SRC_PIXEL = 3'h1, SRC_DUMMY_HI = 3'h2,
      SRC_DUMMY_LO = 3'h3, SRC_TEST_HI = 3'h4, SRC_TEST_LO = 3'h5,
      SRC_FILLER_PAD = 3'h6
   } prs_src_e;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001, ST_WAIT = 3'b010, ST_RUN = 3'b100
   } prs_state_e;
   typedef struct packed {
      logic left_subframe;
      prs_src_e src;
      logic [2:0] filler;
      logic [6:0] row;
      logic [5:0] col;
   } prs_serial_s;
   typedef struct packed {
      prs_src_e left_src;
      prs_src_e right_src;
      logic [6:0] row;
      logic [5:0] col;
   } prs_par_s;
endpackage

// ---- logic/prs_sequencer.sv ----
/*
 * Pixel readout sequencer: orders analogue samples of two subframes
 * on a serial and a parallel stream, with markers and an APB port.
 * Assumes sync_token is asynchronous and the analogue mux decodes
 * the source codes.
 */
`timescale 1ns/100ps
module prs_sequencer (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic sync_token,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output prs_pkg::prs_serial_s serial_sel,
   output prs_pkg::prs_par_s parallel_sel,
   output logic divided_pixel_clock,
   output logic pixel_sample_marker,
   output logic row_end_marker,
   output logic frame_end_marker
);
   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   logic [2:0] sync_ff_q;
   logic sync_lvl_q;
   logic armed_q;
   prs_pkg::prs_state_e state_q;
   logic [3:0] slot_q;
   logic [2:0] lat_q;
   logic [6:0] row_q;
   logic [6:0] pos_q;
   logic first_frame_q;
   logic [2:0] tidx_q;
   logic [4:0] cfg_q;
   logic [4:0] mode_q;

   // -----------------------------------------------------------------
   // Decode
   // -----------------------------------------------------------------
   wire pix_tick = slot_q == prs_pkg::SLOT_LAST;
   wire [3:0] slot_nx = pix_tick ? 4'h0 : 4'(slot_q + 4'h1);
   wire run = state_q == prs_pkg::ST_RUN;
   wire start_w = state_q == prs_pkg::ST_IDLE && pix_tick && armed_q &&
      !sync_lvl_q;
   wire go_run = state_q == prs_pkg::ST_WAIT && pix_tick &&
      lat_q == 3'(prs_pkg::START_LAT - 3'h1);
   wire row_done = pos_q == prs_pkg::POS_LAST;
   wire test_m = mode_q[prs_pkg::MODE_TEST_BIT];
   wire ser_m = mode_q[prs_pkg::MODE_SERIAL_BIT];
   wire mark_all = mode_q[prs_pkg::MODE_MARK_BIT];
   wire active = pos_q >= prs_pkg::POS_PX0;
   wire real_slot = slot_q < prs_pkg::SLOT_FILL0;
   wire [5:0] col_w = 6'(prs_pkg::POS_LAST - pos_q);
   wire [1:0] pidx = 2'(pos_q - prs_pkg::POS_PX0);
   wire par_hi = prs_pkg::PAR_LEFT_PAT[pidx];
   wire tst_left = prs_pkg::SER_TST_LEFT[tidx_q];
   wire tst_hi = prs_pkg::SER_TST_HIGH[tidx_q];
   wire tst_step = run && ser_m && test_m && active && real_slot;

   // Dummies lead every row, in normal and test mode alike
   wire prs_pkg::prs_src_e head_src = pos_q == 7'h00 ?
      prs_pkg::SRC_DUMMY_HI : prs_pkg::SRC_DUMMY_LO;
   wire prs_pkg::prs_src_e ser_src = !run ? prs_pkg::SRC_IDLE :
      !real_slot ? prs_pkg::SRC_FILLER_PAD :
      !active ? head_src :
      !test_m ? prs_pkg::SRC_PIXEL :
      tst_hi ? prs_pkg::SRC_TEST_HI : prs_pkg::SRC_TEST_LO;
   wire ser_left = real_slot && (test_m && active ? tst_left :
      slot_q == 4'h0);
   wire [2:0] filler_w = real_slot ? 3'h0 :
      3'(4'h9 - slot_q);
   wire prs_pkg::prs_src_e par_l = !run ? prs_pkg::SRC_IDLE :
      !active ? head_src : !test_m ? prs_pkg::SRC_PIXEL :
      par_hi ? prs_pkg::SRC_TEST_HI : prs_pkg::SRC_TEST_LO;
   wire prs_pkg::prs_src_e par_r = !run ? prs_pkg::SRC_IDLE :
      !active ? head_src : !test_m ? prs_pkg::SRC_PIXEL :
      par_hi ? prs_pkg::SRC_TEST_LO : prs_pkg::SRC_TEST_HI;
   wire first_pix = first_frame_q && row_q == prs_pkg::ROW_TOP &&
      pos_q == 7'h00;
   wire mark_w = run && (mark_all ? slot_q == 4'h0 : first_pix);

   // -----------------------------------------------------------------
   // Sync token input and pixel clock divider
   // -----------------------------------------------------------------
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         sync_ff_q <= 3'h0;
         sync_lvl_q <= 1'b0;
         // Parked at the wrap so the first high phase is full
         slot_q <= prs_pkg::SLOT_LAST;
         divided_pixel_clock <= 1'b0;
      end else begin
         sync_ff_q <= {sync_ff_q[1:0], sync_token};
         if (sync_ff_q[1] == sync_ff_q[2])
            sync_lvl_q <= sync_ff_q[2];
         slot_q <= slot_nx;
         divided_pixel_clock <= slot_nx < prs_pkg::SLOT_HALF;
      end
   end

   // -----------------------------------------------------------------
   // Frame sequencer
   // -----------------------------------------------------------------
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= prs_pkg::ST_IDLE;
         armed_q <= 1'b0;
         lat_q <= 3'h0;
         row_q <= prs_pkg::ROW_TOP;
         pos_q <= 7'h00;
         first_frame_q <= 1'b1;
         mode_q <= prs_pkg::MODE_RST;
      end else if (sync_lvl_q) begin
         state_q <= prs_pkg::ST_IDLE;
         armed_q <= 1'b1;
         first_frame_q <= 1'b1;
      end else begin
         case (state_q)
            prs_pkg::ST_IDLE: begin
               if (start_w) begin
                  state_q <= prs_pkg::ST_WAIT;
                  armed_q <= 1'b0;
                  lat_q <= 3'h0;
                  mode_q <= cfg_q;
               end
            end
            prs_pkg::ST_WAIT: begin
               if (go_run) begin
                  state_q <= prs_pkg::ST_RUN;
                  row_q <= prs_pkg::ROW_TOP;
                  pos_q <= 7'h00;
               end else if (pix_tick) begin
                  lat_q <= 3'(lat_q + 3'h1);
               end
            end
            prs_pkg::ST_RUN: begin
               if (pix_tick && row_done) begin
                  pos_q <= 7'h00;
                  row_q <= 7'(row_q - 7'h01);
                  if (row_q == 7'h00)
                     first_frame_q <= 1'b0;
               end else if (pix_tick) begin
                  pos_q <= 7'(pos_q + 7'h01);
               end
            end
            default: state_q <= prs_pkg::ST_IDLE;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Stream and marker outputs, one cycle behind the slot counter
   // -----------------------------------------------------------------
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         tidx_q <= 3'h0;
         serial_sel <= '0;
         parallel_sel <= '0;
         pixel_sample_marker <= 1'b0;
         row_end_marker <= 1'b0;
         frame_end_marker <= 1'b0;
      end else begin
         if (!run)
            tidx_q <= 3'h0;
         else if (tst_step)
            tidx_q <= 3'(tidx_q + 3'h1);
         serial_sel <= '{ser_left, ser_src, filler_w, row_q, col_w};
         parallel_sel <= '{par_l, par_r, row_q, col_w};
         pixel_sample_marker <= mark_w;
         row_end_marker <= run && row_done;
         frame_end_marker <= run && row_q == 7'h00;
      end
   end

   // -----------------------------------------------------------------
   // APB slave: no wait states, the answer comes in the first access cycle
   // -----------------------------------------------------------------
   wire apb_setup = psel && !penable;
   wire apb_done = psel && penable && pready;
   wire hit_mode = paddr == prs_pkg::ADDR_MODE;
   wire hit_stat = paddr == prs_pkg::ADDR_STAT;
   wire [31:0] rd_w = hit_mode ? {27'h0, cfg_q} :
      hit_stat ? {9'h0, state_q, row_q, 6'h0, pos_q} : 32'h0;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_q <= prs_pkg::MODE_RST;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= apb_setup;
         pslverr <= apb_setup && !hit_mode && !hit_stat;
         prdata <= apb_setup && !pwrite ? rd_w : 32'h0;
         if (apb_done && pwrite && hit_mode)
            cfg_q <= pwdata[4:0];
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   wire run_ser = run && ser_m && !sync_lvl_q;

   sequence s_real_pair;
      serial_sel.left_subframe && serial_sel.src == prs_pkg::SRC_PIXEL
      ##1 !serial_sel.left_subframe &&
      serial_sel.src == prs_pkg::SRC_PIXEL;
   endsequence
   sequence s_fillers;
      (serial_sel.src == prs_pkg::SRC_FILLER_PAD)[*8];
   endsequence

   property p_slot_wrap;
      @(posedge clock) disable iff (sys_rst)
      pix_tick |=> slot_q == 4'h0 ##9 pix_tick;
   endproperty
   a_slot_wrap: assert property (p_slot_wrap)
      else $error("slot counter does not wrap at ten");

   property p_div_clock;
      @(posedge clock) disable iff (sys_rst)
      $rose(divided_pixel_clock) |=> divided_pixel_clock[*4]
      ##1 !divided_pixel_clock[*5] ##1 divided_pixel_clock;
   endproperty
   a_div_clock: assert property (p_div_clock)
      else $error("divided clock is not one tenth");

   property p_start;
      @(posedge clock) disable iff (sys_rst)
      go_run && !sync_lvl_q |=> run && row_q == prs_pkg::ROW_TOP &&
      pos_q == 7'h00 && $past(lat_q) == 3'h3;
   endproperty
   a_start: assert property (p_start)
      else $error("readout start latency wrong");

   property p_serial_order;
      @(posedge clock) disable iff (sys_rst || sync_lvl_q)
      run_ser && !test_m && active && slot_q == 4'h0 && !pix_tick
      |=> s_real_pair ##1 s_fillers;
   endproperty
   a_serial_order: assert property (p_serial_order)
      else $error("serial slot order broken");

   property p_filler_top;
      @(posedge clock) disable iff (sys_rst || sync_lvl_q)
      run_ser && slot_q == prs_pkg::SLOT_FILL0 |=>
      serial_sel.filler == 3'h7 ##7 serial_sel.filler == 3'h0;
   endproperty
   a_filler_top: assert property (p_filler_top)
      else $error("filler numbering wrong");

   property p_dummy_first;
      @(posedge clock) disable iff (sys_rst)
      run && pos_q == 7'h00 && !sync_lvl_q |=>
      parallel_sel.left_src == prs_pkg::SRC_DUMMY_HI &&
      parallel_sel.right_src == prs_pkg::SRC_DUMMY_HI;
   endproperty
   a_dummy_first: assert property (p_dummy_first)
      else $error("row does not start with high dummy");

   property p_par_test;
      @(posedge clock) disable iff (sys_rst)
      run && test_m && active && !sync_lvl_q |=>
      parallel_sel.left_src != parallel_sel.right_src &&
      parallel_sel.left_src != prs_pkg::SRC_PIXEL;
   endproperty
   a_par_test: assert property (p_par_test)
      else $error("parallel test levels not complementary");

   // Marker trails the row state by one clock
   property p_row_end;
      @(posedge clock) disable iff (sys_rst || sync_lvl_q)
      row_end_marker && pix_tick |=> pos_q == 7'h00 ##1
      !row_end_marker;
   endproperty
   a_row_end: assert property (p_row_end)
      else $error("row end marker not a row pulse");

   property p_frame_end;
      @(posedge clock) disable iff (sys_rst)
      frame_end_marker |-> $past(row_q) == 7'h00 && $past(run);
   endproperty
   a_frame_end: assert property (p_frame_end)
      else $error("frame end marker outside last row");

   property p_marker;
      @(posedge clock) disable iff (sys_rst)
      run && mark_all && slot_q == 4'h0 |=> pixel_sample_marker
      ##1 !pixel_sample_marker;
   endproperty
   a_marker: assert property (p_marker)
      else $error("sample marker missing");

   property p_resync;
      @(posedge clock) disable iff (sys_rst)
      sync_lvl_q |=> state_q == prs_pkg::ST_IDLE ##1 !run;
   endproperty
   a_resync: assert property (p_resync)
      else $error("sync token did not resynchronise");
endmodule

// ---- verif/prs_daq_model.sv ----
/*
 * Acquisition board model: owns the frame sync pin and times the
 * first analogue sample after each sync fall.
 * Assumes it shares the sequencer clock and reset.
 */
`timescale 1ns/100ps
module prs_daq_model #(
   parameter int SYNC_HOLD = 30
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic resync,
   input wire prs_pkg::prs_serial_s serial_sel,
   input wire prs_pkg::prs_par_s parallel_sel,
   output logic sync_token,
   output logic [7:0] first_lat
);
   logic [7:0] hold_q;
   logic counting_q;
   wire seen = (serial_sel.src != prs_pkg::SRC_IDLE) ||
      (parallel_sel.left_src != prs_pkg::SRC_IDLE);

   // -----------------------------------------------------------------
   // Sync token: high for a while, then a clean fall
   // -----------------------------------------------------------------
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         sync_token <= 1'b0;
         hold_q <= 8'h00;
         counting_q <= 1'b0;
         first_lat <= 8'h00;
      end else if (resync) begin
         sync_token <= 1'b1;
         hold_q <= 8'(SYNC_HOLD);
         counting_q <= 1'b0;
         first_lat <= 8'h00;
      end else if (hold_q != 8'h00) begin
         hold_q <= hold_q - 8'h01;
         if (hold_q == 8'h01) begin
            sync_token <= 1'b0;
            counting_q <= 1'b1;
         end
      end else if (counting_q) begin
         if (seen) begin
            counting_q <= 1'b0;
         end else begin
            first_lat <= first_lat + 8'h01;
         end
      end
   end
endmodule

// ---- verif/tb_pixel_readout_sequencer.sv ----
/*
 * Self-checking bench of the pixel readout sequencer.
 * Assumes the acquisition board model drives the sync pin.
 */
`timescale 1ns/100ps
module tb_pixel_readout_sequencer;
   typedef struct {
      logic wr;
      logic [11:0] a;
      logic [31:0] d;
      logic [31:0] x;
      logic e;
   } prs_row_s;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic resync = 1'b0;
   logic sync_token, pready, pslverr, divided_pixel_clock;
   logic pixel_sample_marker, row_end_marker, frame_end_marker, er, pv;
   logic [31:0] prdata, rd;
   logic [7:0] first_lat;
   prs_pkg::prs_serial_s serial_sel;
   prs_pkg::prs_par_s parallel_sel;
   int err_count = 0;
   int checks_done = 0;
   int n, hc, tc;
   prs_row_s rows[8] = '{'{1, 12'h000, 32'hFFFFFFFF, 32'h0, 0},
      '{0, 12'h000, 32'h0, 32'h1F, 0}, '{1, 12'h000, 32'h0A, 32'h0, 0},
      '{0, 12'h000, 32'h0, 32'h0A, 0}, '{1, 12'h004, 32'hF, 32'h0, 0},
      '{0, 12'h008, 32'h0, 32'h0, 1}, '{1, 12'h00C, 32'h1, 32'h0, 1},
      '{1, 12'h000, 32'h14, 32'h0, 0}};

   always #5 clock = ~clock;

   prs_sequencer uut (.clock(clock), .sys_rst(sys_rst),
      .sync_token(sync_token), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serial_sel(serial_sel), .parallel_sel(parallel_sel),
      .divided_pixel_clock(divided_pixel_clock),
      .pixel_sample_marker(pixel_sample_marker),
      .row_end_marker(row_end_marker),
      .frame_end_marker(frame_end_marker));
   prs_daq_model daq (.clock(clock), .sys_rst(sys_rst), .resync(resync),
      .serial_sel(serial_sel), .parallel_sel(parallel_sel),
      .sync_token(sync_token), .first_lat(first_lat));

   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
         input string what);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a,
         input logic [31:0] d, output logic [31:0] q, output logic e);
      int i;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      i = 1;
      @(posedge clock);
      while (pready !== 1'b1) begin
         @(posedge clock);
         i++;
      end
      chk(i, 1, "pready wait");
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask

   task automatic start_run(input logic par);
      int i;
      resync <= 1'b1;
      @(posedge clock);
      resync <= 1'b0;
      repeat (25) @(posedge clock);
      for (i = 0; i < 200; i++) begin
         @(posedge clock);
         if ((par ? parallel_sel.left_src : serial_sel.src) !==
            prs_pkg::SRC_IDLE) break;
      end
      chk(32'(first_lat >= 40 && first_lat <= 56), 32'h1,
         "latency");
   endtask

   task automatic ser_check(input int npix, input logic tst,
         input logic mk);
      int p, s, k;
      prs_pkg::prs_src_e src;
      logic lf;
      k = 0;
      for (p = 0; p < npix; p++) begin
         for (s = 0; s < 10; s++) begin
            lf = (s == 0);
            if (s > 1) src = prs_pkg::SRC_FILLER_PAD;
            else if (p < 2) src = p ? prs_pkg::SRC_DUMMY_LO
               : prs_pkg::SRC_DUMMY_HI;
            else if (!tst) src = prs_pkg::SRC_PIXEL;
            else begin
               // Left and high bits of the eight test entries
               lf = 1'((8'h15 >> k) & 8'h01);
               src = (8'h69 >> k) & 1 ? prs_pkg::SRC_TEST_HI
                  : prs_pkg::SRC_TEST_LO;
               k++;
            end
            chk(serial_sel.src, src,
               "serial source");
            if (s > 1) chk(serial_sel.filler, 32'(9 - s),
               "filler");
            else chk(serial_sel.left_subframe, lf,
               "subframe");
            if (!tst && p == 2 && s == 0) chk({serial_sel.row, serial_sel.col},
               {7'h7F, 6'h3F}, "first pixel");
            if (mk) chk(pixel_sample_marker, s == 0,
               "marker");
            @(posedge clock);
         end
      end
   endtask

   task automatic par_check(input int npix, input logic tst);
      int p;
      logic hi;
      prs_pkg::prs_src_e l, r;
      repeat (4) @(posedge clock);
      for (p = 0; p < npix; p++) begin
         hi = p < 2 ? p == 0 : ((p - 2) % 4 == 0 || (p - 2) % 4 == 3);
         l = hi ? prs_pkg::SRC_TEST_HI : prs_pkg::SRC_TEST_LO;
         r = hi ? prs_pkg::SRC_TEST_LO : prs_pkg::SRC_TEST_HI;
         if (!tst) l = prs_pkg::SRC_PIXEL;
         if (!tst) r = prs_pkg::SRC_PIXEL;
         if (p < 2) l = hi ? prs_pkg::SRC_DUMMY_HI : prs_pkg::SRC_DUMMY_LO;
         if (p < 2) r = l;
         chk(parallel_sel.left_src, l,
            "left output");
         chk(parallel_sel.right_src, r, "right output");
         chk(pixel_sample_marker, p == 0, "first marker");
         repeat (10) @(posedge clock);
      end
   endtask

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clock);
      chk(serial_sel, 32'h0, "serial in reset");
      chk(parallel_sel, 32'h0, "parallel in reset");
      chk({pready, pixel_sample_marker, row_end_marker, frame_end_marker},
         32'h0, "flags in reset");
      sys_rst <= 1'b0;
      @(posedge clock);
      apb(1'b0, 12'h000, 32'h0, rd, er);
      chk(rd, 32'h14, "mode reset value");
      $display("test reset done");
      for (n = 0; n < 8; n++) begin
         apb(rows[n].wr, rows[n].a, rows[n].d, rd, er);
         chk(er, rows[n].e, "slave error");
         if (!rows[n].wr) chk(rd, rows[n].x, "read data");
      end
      $display("test registers done");
      start_run(1'b0);
      ser_check(3, 1'b0, 1'b1);
      hc = 0;
      tc = 0;
      pv = divided_pixel_clock;
      repeat (20) begin
         @(posedge clock);
         hc += divided_pixel_clock;
         tc += divided_pixel_clock && !pv;
         pv = divided_pixel_clock;
      end
      chk(hc, 10, "divided high");
      chk(tc, 2, "divided rises");
      for (n = 0; n < 800 && row_end_marker !== 1'b1; n++) @(posedge clock);
      @(posedge clock);
      chk({serial_sel.row, serial_sel.col}, {7'h7F, 6'h00},
         "row end");
      for (n = 0; n < 20 && row_end_marker !== 1'b0; n++) @(posedge clock);
      chk(serial_sel.src, prs_pkg::SRC_DUMMY_HI, "next row");
      chk(serial_sel.row, 7'h7E, "next row index");
      hc = 0;
      pv = 1'b0;
      for (n = 0; n < 90000 && frame_end_marker !== 1'b1; n++) begin
         @(posedge clock);
         hc += row_end_marker && !pv;
         pv = row_end_marker;
      end
      chk(hc, 126, "row ends");
      repeat (5) @(posedge clock);
      chk(serial_sel.row, 7'h00, "last row");
      $display("test serial normal done");
      apb(1'b1, 12'h000, 32'h01, rd, er);
      start_run(1'b1);
      par_check(10, 1'b1);
      $display("test parallel test done");
      apb(1'b1, 12'h000, 32'h00, rd, er);
      start_run(1'b1);
      par_check(4, 1'b0);
      $display("test parallel normal done");
      apb(1'b1, 12'h000, 32'h05, rd, er);
      start_run(1'b0);
      ser_check(6, 1'b1, 1'b0);
      $display("test serial test done");
      wrap_up;
   end

   initial begin
      #1000000;
      err_count++;
      wrap_up;
   end
endmodule
